/* pkg/acr_consts.svh */
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

`define ACR_CLK_MHZ          50
`define ACR_PWRUP_NS         1500
`define ACR_PWRUP_CYC        ((`ACR_PWRUP_NS * `ACR_CLK_MHZ) / 1000)
`define ACR_CONV_NS          4500
`define ACR_CONV_CYC         ((`ACR_CONV_NS * `ACR_CLK_MHZ) / 1000)
`define ACR_CNT_W            8
`define ACR_RES_W            8
`define ACR_RES_RST          8'h00

`endif

/* pkg/acr_pkg.sv */
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_DOWN  = 2'b00,
        ACR_PWRUP = 2'b01,
        ACR_IDLE  = 2'b11,
        ACR_CONV  = 2'b10
    } acr_state_t;
endpackage

/* pkg/acr_sar_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acr_sar_if;
    logic       start;
    logic [7:0] sample;
    logic       done;
    logic [7:0] code;
    modport ctrl (output start, output sample, input done, input code);
    modport sar  (input start, input sample, output done, output code);
endinterface
`default_nettype wire

/* design/acr_sar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.svh"
// successive approximation: one bit per step, msb first, straight binary code
module acr_sar (
    input  wire logic      clk,
    input  wire logic      rst,
    acr_sar_if.sar         bus
);
    localparam logic [`ACR_CNT_W-1:0] STEP_CYC = `ACR_CNT_W'(`ACR_CONV_CYC / 9);

    logic [7:0]            trial_r;
    logic [7:0]            bit_r;
    logic [7:0]            held_r;
    logic [`ACR_CNT_W-1:0] cnt_r;
    logic                  run_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trial_r  <= 8'h00;
            bit_r    <= 8'h00;
            held_r   <= 8'h00;
            cnt_r    <= '0;
            run_r    <= 1'b0;
            bus.done <= 1'b0;
            bus.code <= `ACR_RES_RST;
        end else begin
            bus.done <= 1'b0;
            if (bus.start) begin
                held_r  <= bus.sample;
                trial_r <= 8'h80;
                bit_r   <= 8'h80;
                cnt_r   <= '0;
                run_r   <= 1'b1;
            end else if (run_r) begin
                if (cnt_r == STEP_CYC - `ACR_CNT_W'(1)) begin
                    cnt_r <= '0;
                    // drop the trial bit if it overshoots the held input
                    if (trial_r > held_r) begin
                        trial_r <= (trial_r & ~bit_r) | (bit_r >> 1);
                    end else begin
                        trial_r <= trial_r | (bit_r >> 1);
                    end
                    bit_r <= bit_r >> 1;
                    if (bit_r == 8'h01) begin
                        run_r    <= 1'b0;
                        bus.done <= 1'b1;
                        bus.code <= (trial_r > held_r) ? (trial_r & ~bit_r) : trial_r;
                    end
                end else begin
                    cnt_r <= cnt_r + `ACR_CNT_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* design/acr_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.svh"
// Summary of operation
// - rising convert_start_n edge starts a 1.5 us internal power-up pulse
// - falling edge converts only after that pulse ends, else waits for it
// - at conversion end, convert_start_n level decides power-down or stay up
// - result drives the bus only while chip select and read are both low
// - busy is high throughout each conversion and low otherwise
// - result is eight three-state bits, zero through seven
// - busy rises on falling convert_start_n, or at power-up end for a fall seen during the pulse, and falls at conversion end
// - each conversion completes within 4.5 us, then result is readable
// - result is straight unsigned binary, one step per reference over 256
// - after reset the block is powered down until a rising convert_start_n
module acr_top (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       convert_start_n,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic [7:0] analog_in,
    output logic            busy,
    output logic [7:0]      result_bus_o,
    output logic [7:0]      result_bus_oe,
    output logic            powered
);
    localparam logic [`ACR_CNT_W-1:0] PWRUP_CYC = `ACR_CNT_W'(`ACR_PWRUP_CYC);

    acr_sar_if sar_bus ();

    acr_sar u_sar (
        .clk (clk),
        .rst (rst),
        .bus (sar_bus)
    );

    // pins come from the host's domain
    logic [1:0] cs_sync_r;
    logic [1:0] cs_meta_r;
    logic       cs_prev_r;
    logic [1:0] rd_meta_r;
    logic [7:0] ain_meta_r;
    logic [7:0] ain_r;

    // history resets low, matching the start pin held low through reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_sync_r <= 2'b00;
            cs_prev_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], convert_start_n};
            cs_prev_r <= cs_sync_r[1];
        end
    end

    // select and read idle high, so the bus stays released through reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_meta_r <= 2'b11;
            rd_meta_r <= 2'b11;
        end else begin
            cs_meta_r <= {cs_meta_r[0], cs_n};
            rd_meta_r <= {rd_meta_r[0], rd_n};
        end
    end

    // stand-in input word; the host must hold it steady around a start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ain_meta_r <= 8'h00;
            ain_r      <= 8'h00;
        end else begin
            ain_meta_r <= analog_in;
            ain_r      <= ain_meta_r;
        end
    end

    logic start_lvl;
    logic start_rise;
    logic start_fall;
    assign start_lvl  = cs_sync_r[1];
    assign start_rise = start_lvl & ~cs_prev_r;
    assign start_fall = ~start_lvl & cs_prev_r;

    acr_pkg::acr_state_t   state_r;
    logic [`ACR_CNT_W-1:0] pw_cnt_r;
    logic                  pw_done;
    logic                  pend_r;
    logic                  go;

    // a fall seen during the power-up pulse is remembered, not dropped
    assign go = (state_r == acr_pkg::ACR_IDLE) && (start_fall || pend_r);
    assign pw_done = (pw_cnt_r == PWRUP_CYC - `ACR_CNT_W'(1));

    // counter idles at zero, so every entry to power-up gets the full pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pw_cnt_r <= '0;
        end else if (state_r != acr_pkg::ACR_PWRUP) begin
            pw_cnt_r <= '0;
        end else if (!pw_done) begin
            pw_cnt_r <= pw_cnt_r + `ACR_CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= acr_pkg::ACR_DOWN;
        end else begin
            case (state_r)
                acr_pkg::ACR_DOWN: begin
                    if (start_rise) begin
                        state_r <= acr_pkg::ACR_PWRUP;
                    end
                end
                acr_pkg::ACR_PWRUP: begin
                    if (pw_done) begin
                        state_r <= acr_pkg::ACR_IDLE;
                    end
                end
                acr_pkg::ACR_IDLE: begin
                    if (go) begin
                        state_r <= acr_pkg::ACR_CONV;
                    end else if (start_rise) begin
                        state_r <= acr_pkg::ACR_PWRUP;
                    end
                end
                acr_pkg::ACR_CONV: begin
                    if (sar_bus.done) begin
                        // sampled level picks power-down or high-speed mode
                        state_r <= start_lvl ? acr_pkg::ACR_IDLE
                                             : acr_pkg::ACR_DOWN;
                    end
                end
                default: state_r <= acr_pkg::ACR_DOWN;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (go || state_r == acr_pkg::ACR_DOWN) begin
            pend_r <= 1'b0;
        end else if (start_fall && state_r == acr_pkg::ACR_PWRUP) begin
            pend_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sar_bus.start <= 1'b0;
        end else begin
            sar_bus.start <= go;
        end
    end

    // the converter latches this only on its start strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sar_bus.sample <= 8'h00;
        end else begin
            sar_bus.sample <= ain_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
        end else if (sar_bus.done) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powered <= 1'b0;
        end else begin
            powered <= (state_r != acr_pkg::ACR_DOWN);
        end
    end

    // last completed code, held until the next conversion ends
    logic [7:0] result_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_r <= `ACR_RES_RST;
        end else if (sar_bus.done) begin
            result_r <= sar_bus.code;
        end
    end

    // both strobes seen low after their synchronisers
    logic sel_rd;
    assign sel_rd = ~cs_meta_r[1] & ~rd_meta_r[1];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_bus_o <= 8'h00;
        end else begin
            result_bus_o <= result_r;
        end
    end

    // two-flop sync adds latency; a read strobe must last a few clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_bus_oe <= 8'h00;
        end else begin
            result_bus_oe <= {8{sel_rd}};
        end
    end
endmodule
`default_nettype wire

/* tb/acr_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_top_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       convert_start_n,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic [7:0] analog_in,
    input wire logic       busy,
    input wire logic [7:0] result_bus_o,
    input wire logic [7:0] result_bus_oe,
    input wire logic       powered
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_oe_needs_sel: assert property (|result_bus_oe
        |-> !$past(cs_n, 3) && !$past(rd_n, 3))
        else $error("bus driven unselected");
    a_oe_whole_byte: assert property (result_bus_oe == 8'h00 || result_bus_oe == 8'hff)
        else $error("partial enable");
    a_busy_ends: assert property ($rose(busy) |-> ##[1:226] !busy)
        else $error("conversion too long");
    a_busy_holds: assert property ($rose(busy) |-> busy[*8])
        else $error("busy glitch");
    a_result_hold: assert property ($changed(result_bus_o)
        |-> !$past(busy) && $past(busy, 2))
        else $error("result moved mid conversion");
    a_power_rise: assert property ($rose(powered) |-> $past(convert_start_n, 3))
        else $error("woke without rising start");
    a_stay_up: assert property ($fell(busy) && convert_start_n
        && $past(convert_start_n, 4) |-> ##2 powered)
        else $error("dropped power with start high");
    a_go_down: assert property ($fell(busy) && !convert_start_n
        && !$past(convert_start_n, 4) |-> ##2 !powered)
        else $error("stayed up with start low");
    cover property ($fell(busy) && convert_start_n);
    cover property ($fell(busy) && !convert_start_n);
    cover property (result_bus_oe == 8'hff);
endmodule
bind acr_top acr_top_props u_props (.clk(clk), .rst(rst), .convert_start_n(convert_start_n),
    .cs_n(cs_n), .rd_n(rd_n), .analog_in(analog_in), .busy(busy),
    .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe), .powered(powered));
`default_nettype wire

/* tb/acr_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host side: reads the result after busy falls, after a variable delay
module acr_host (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic [7:0] bus_o,
    input  wire logic [7:0] bus_oe,
    input  wire logic [3:0] lag,
    output logic            cs_n,
    output logic            rd_n,
    output logic [7:0]      got,
    output logic            got_v
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        got = 8'h00;
        got_v = 1'b0;
        forever begin
            @(negedge busy);
            repeat (lag) @(posedge clk);
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            repeat (6) @(posedge clk);
            // undriven lines read as the inverse of the value, not a lucky match
            got <= (bus_o & bus_oe) | (~bus_o & ~bus_oe);
            got_v <= ~got_v;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/acr_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module acr_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        conv_n = 1'b0;
    logic [7:0]  ain = 8'h00;
    logic [3:0]  lag = 4'h0;
    logic [31:0] seed = 32'h000106d7;
    logic        cs_n, rd_n, busy, powered, got_v, stay, early, was;
    logic [7:0]  bus_o, bus_oe, got;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t;
    always #10 clk = ~clk;
    acr_top dut (.clk(clk), .rst(rst), .convert_start_n(conv_n), .cs_n(cs_n), .rd_n(rd_n),
        .analog_in(ain), .busy(busy), .result_bus_o(bus_o), .result_bus_oe(bus_oe),
        .powered(powered));
    acr_host host (.clk(clk), .busy(busy), .bus_o(bus_o), .bus_oe(bus_oe), .lag(lag),
        .cs_n(cs_n), .rd_n(rd_n), .got(got), .got_v(got_v));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // straight binary: code equals input in steps of reference over 256
    function automatic logic [7:0] exp_code(input logic [7:0] a);
        return a;
    endfunction
    task automatic end_of_test;
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(powered, 1'b0)
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            stay = seed[0] ^ (i == 1);
            early = (seed[1] | (i == 0)) & !powered;
            lag <= seed[7:4];
            ain <= seed[15:8];
            if (!powered) begin
                conv_n <= 1'b1;
                repeat (early ? 10 : 100) @(posedge clk);
            end
            conv_n <= 1'b0;
            t = 0;
            do begin @(posedge clk); t++; end while (!busy && t < 300);
            `CHK(t > 10, early)
            `CHK(busy, 1'b1)
            `CHK(t > 60 && t < 75, early)
            if (stay) conv_n <= 1'b1;
            was = got_v;
            t = 0;
            do begin @(posedge clk); t++; end while (busy && t < 300);
            `CHK(t <= 226, 1'b1)
            repeat (3) @(posedge clk);
            `CHK(powered, stay)
            t = 0;
            while (got_v === was && t < 40) begin @(posedge clk); t++; end
            `CHK(got_v !== was, 1'b1)
            `CHK(got, exp_code(ain))
            repeat (4) @(posedge clk);
            `CHK(bus_oe, 8'h00)
        end
        end_of_test();
    end
endmodule
`default_nettype wire
